/* core/crh_pkg.sv */
package crh_pkg;
   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NBUF = 16;
   localparam int BUFW = 4;
   localparam int HIST_DEPTH = 23;
   localparam int HPW = 5;
   localparam int IDW = 29;
   localparam int DLCW = 4;
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int NMASK = 4;

   // ----------------------------------------------------------------
   // buffer type codes, ordered by storing priority (low code wins)
   // ----------------------------------------------------------------
   localparam logic [2:0] TYPE_UNMASKED = 3'h1;
   localparam logic [2:0] TYPE_MASK1 = 3'h2;
   localparam logic [2:0] TYPE_MASK4 = 3'h5;
   localparam logic [2:0] TYPE_NONE = 3'h7;

   // ----------------------------------------------------------------
   // timing: copy phase of a store, a least time
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int STORE_TIME_NS = 20;
   localparam int STORE_CYCLES_I = (STORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] STORE_CYCLES = 4'(STORE_CYCLES_I);

   // ----------------------------------------------------------------
   // register word addresses
   // ----------------------------------------------------------------
   localparam logic [AW-1:0] ADDR_CFG_BASE = 8'h00;
   localparam logic [AW-1:0] ADDR_CTRL_BASE = 8'h10;
   localparam logic [AW-1:0] ADDR_ID_BASE = 8'h20;
   localparam logic [AW-1:0] ADDR_MASK_BASE = 8'h30;
   localparam logic [AW-1:0] ADDR_HGET = 8'h34;
   localparam logic [AW-1:0] ADDR_LAST = 8'h35;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CFG_USE_BIT = 0;
   localparam int CFG_TYPE_LSB = 1;
   localparam int CFG_OWS_BIT = 4;
   localparam int CTRL_RDY_BIT = 0;
   localparam int CTRL_DN_BIT = 1;
   localparam int CTRL_MUC_BIT = 2;
   localparam int CTRL_DLC_LSB = 8;
   localparam int CTRLW_CLR_RDY = 0;
   localparam int CTRLW_CLR_DN = 1;
   localparam int CTRLW_SET_RDY = 8;
   localparam int ID_IDE_BIT = 31;
   localparam int HGET_EMPTY_BIT = 8;
   localparam int HGET_OVF_BIT = 9;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic RST_FLAG = 1'b0;
   localparam logic RST_EMPTY = 1'b1;
   localparam logic [HPW-1:0] RST_PTR = 5'h00;
   localparam logic [2:0] RST_TYPE = 3'h0;
   localparam logic [DW-1:0] RST_RDATA = 32'h0000_0000;

   typedef enum logic [2:0] {ST_IDLE, ST_SEARCH, ST_HIST, ST_START, ST_COPY} crh_state_e;
endpackage

/* core/crh_rx_store.sv */
// Contract
// - search only used, receive-type, ready buffers
// - store only in highest-priority match
// - blocked top match discards, no redirect
// - rank unmasked, mask1..mask4 lowest
// - accept if new-data clear or overwrite
// - new-data set at start and end
// - in-progress held during store, cleared at end
// - history written just before copy
// - ready flag locked while storing
// - copy may stall on CPU buffer access
// - history list holds 23 buffer numbers
// - history contents undefined after mode entry
// - last-in reads entry below write pointer
// - record at write pointer, then increment
// - get read returns oldest, then increments
// - empty when pointers equal, cleared on store
// - overflow when write pointer hits read-1
// - full list overwrites newest entry
// - overflow sticky; blocks empty clear
// - reads served in overflow until empty
// - buffer picks no mask or one of four
// - mask bit 1 skips, 0 compares
module crh_rx_store (
   input wire logic sys_clk, // module clock
   input wire logic srst, // synchronous reset, high
   input wire logic [7:0] reg_addr, // register word address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [31:0] reg_rdata, // read data, cycle after strobe
   input wire logic rx_valid, // received data frame offered
   input wire logic [28:0] rx_id, // received identifier
   input wire logic rx_ide, // extended format
   input wire logic [3:0] rx_dlc, // received length code
   output logic rx_ready, // frame taken when valid and ready
   output logic store_done, // pulse: frame stored
   output logic [3:0] store_buf, // buffer of the last store
   output logic frame_drop // pulse: matching frame discarded
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic use_q [crh_pkg::NBUF];
   logic [2:0] type_q [crh_pkg::NBUF];
   logic ows_q [crh_pkg::NBUF];
   logic rdy_q [crh_pkg::NBUF];
   logic dn_q [crh_pkg::NBUF];
   logic muc_q [crh_pkg::NBUF];
   logic [28:0] id_q [crh_pkg::NBUF];
   logic ide_q [crh_pkg::NBUF];
   logic [3:0] dlc_q [crh_pkg::NBUF];
   logic [28:0] mask_q [crh_pkg::NMASK];
   logic [3:0] hist_mem [crh_pkg::HIST_DEPTH];
   logic [4:0] wp_q;
   logic [4:0] rp_q;
   logic empty_q;
   logic ovf_q;
   crh_pkg::crh_state_e st_q;
   logic [3:0] cnt_q;
   logic [3:0] tgt_q;
   logic [28:0] fid_q;
   logic fide_q;
   logic [3:0] fdlc_q;
   logic [31:0] rdata_d;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // circular pointer steps over the 23 entries
   function automatic logic [4:0] ptr_inc(input logic [4:0] p);
      return (p == 5'(crh_pkg::HIST_DEPTH - 1)) ? 5'h00 : 5'(p + 5'h01);
   endfunction

   function automatic logic [4:0] ptr_dec(input logic [4:0] p);
      return (p == 5'h00) ? 5'(crh_pkg::HIST_DEPTH - 1) : 5'(p - 5'h01);
   endfunction

   // address hits one register of buffer n in a bank
   function automatic logic bank_hit(input logic [7:0] a, input logic [7:0] base,
                                     input logic [3:0] n);
      return a == 8'(base + {4'h0, n});
   endfunction

   // ----------------------------------------------------------------
   // receive search
   // ----------------------------------------------------------------
   logic [15:0] cand;
   logic [2:0] best_cls;
   logic free_hit;
   logic ows_hit;
   logic [3:0] free_num;
   logic [3:0] ows_num;
   logic found;
   logic [28:0] care;
   logic [28:0] msk;

   // masked compare; a standard id only uses the top 11 bits
   always_comb begin
      care = fide_q ? 29'h1FFF_FFFF : 29'h1FFC_0000;
      for (int i = 0; i < crh_pkg::NBUF; i++) begin
         msk = (type_q[i] == crh_pkg::TYPE_UNMASKED) ? 29'h0000_0000 :
               mask_q[2'(type_q[i] - crh_pkg::TYPE_MASK1)];
         cand[i] = use_q[i] && rdy_q[i] && type_q[i] >= crh_pkg::TYPE_UNMASKED &&
                   type_q[i] <= crh_pkg::TYPE_MASK4 &&
                   ide_q[i] == fide_q &&
                   (((id_q[i] ^ fid_q) & care & ~msk) == 29'h0000_0000);
      end
   end

   // best class first, then lowest free buffer, then lowest overwritable
   always_comb begin
      best_cls = crh_pkg::TYPE_NONE;
      free_hit = 1'b0;
      ows_hit = 1'b0;
      free_num = 4'h0;
      ows_num = 4'h0;
      for (int i = 0; i < crh_pkg::NBUF; i++) begin
         if (cand[i] && type_q[i] < best_cls) begin
            best_cls = type_q[i];
         end
      end
      for (int i = crh_pkg::NBUF - 1; i >= 0; i--) begin
         if (cand[i] && type_q[i] == best_cls && !dn_q[i]) begin
            free_hit = 1'b1;
            free_num = 4'(i);
         end
         if (cand[i] && type_q[i] == best_cls && ows_q[i]) begin
            ows_hit = 1'b1;
            ows_num = 4'(i);
         end
      end
      found = best_cls != crh_pkg::TYPE_NONE;
   end

   // cpu touching the buffer being filled stalls the copy
   logic cpu_touch;
   assign cpu_touch = (reg_wr || reg_rd) &&
                      (bank_hit(reg_addr, crh_pkg::ADDR_CFG_BASE, tgt_q) ||
                       bank_hit(reg_addr, crh_pkg::ADDR_CTRL_BASE, tgt_q) ||
                       bank_hit(reg_addr, crh_pkg::ADDR_ID_BASE, tgt_q));
   logic copy_end;
   assign copy_end = st_q == crh_pkg::ST_COPY && cnt_q == 4'h0 && !cpu_touch;

   // ----------------------------------------------------------------
   // store sequencer
   // ----------------------------------------------------------------
   // one frame at a time; the engine is held off by rx_ready
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q <= crh_pkg::ST_IDLE;
         rx_ready <= 1'b1;
         frame_drop <= 1'b0;
         store_done <= 1'b0;
         store_buf <= 4'h0;
         tgt_q <= 4'h0;
         cnt_q <= 4'h0;
         fid_q <= 29'h0000_0000;
         fide_q <= 1'b0;
         fdlc_q <= 4'h0;
      end else begin
         frame_drop <= 1'b0;
         store_done <= 1'b0;
         unique case (st_q)
            crh_pkg::ST_IDLE: begin
               if (rx_valid && rx_ready) begin
                  fid_q <= rx_id;
                  fide_q <= rx_ide;
                  fdlc_q <= rx_dlc;
                  rx_ready <= 1'b0;
                  st_q <= crh_pkg::ST_SEARCH;
               end
            end
            crh_pkg::ST_SEARCH: begin
               if (free_hit) begin
                  tgt_q <= free_num;
                  st_q <= crh_pkg::ST_HIST;
               end else if (ows_hit) begin
                  tgt_q <= ows_num;
                  st_q <= crh_pkg::ST_HIST;
               end else begin
                  frame_drop <= found;
                  rx_ready <= 1'b1;
                  st_q <= crh_pkg::ST_IDLE;
               end
            end
            crh_pkg::ST_HIST: begin
               st_q <= crh_pkg::ST_START;
            end
            crh_pkg::ST_START: begin
               cnt_q <= 4'(crh_pkg::STORE_CYCLES - 4'h1);
               st_q <= crh_pkg::ST_COPY;
            end
            crh_pkg::ST_COPY: begin
               if (copy_end) begin
                  store_done <= 1'b1;
                  store_buf <= tgt_q;
                  rx_ready <= 1'b1;
                  st_q <= crh_pkg::ST_IDLE;
               end else if (!cpu_touch) begin
                  cnt_q <= 4'(cnt_q - 4'h1);
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // buffer configuration and identifiers
   // ----------------------------------------------------------------
   // layout writes only take effect while the buffer is not ready
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         for (int i = 0; i < crh_pkg::NBUF; i++) begin
            use_q[i] <= crh_pkg::RST_FLAG;
            type_q[i] <= crh_pkg::RST_TYPE;
            ows_q[i] <= crh_pkg::RST_FLAG;
         end
      end else begin
         for (int i = 0; i < crh_pkg::NBUF; i++) begin
            if (reg_wr && !rdy_q[i] && bank_hit(reg_addr, crh_pkg::ADDR_CFG_BASE, 4'(i))) begin
               use_q[i] <= reg_wdata[crh_pkg::CFG_USE_BIT];
               type_q[i] <= reg_wdata[crh_pkg::CFG_TYPE_LSB +: 3];
               ows_q[i] <= reg_wdata[crh_pkg::CFG_OWS_BIT];
            end
         end
      end
   end

   // received id and length land at the end of the copy
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         for (int i = 0; i < crh_pkg::NBUF; i++) begin
            id_q[i] <= 29'h0000_0000;
            ide_q[i] <= 1'b0;
            dlc_q[i] <= 4'h0;
         end
      end else begin
         for (int i = 0; i < crh_pkg::NBUF; i++) begin
            if (copy_end && tgt_q == 4'(i)) begin
               id_q[i] <= fid_q;
               ide_q[i] <= fide_q;
               dlc_q[i] <= fdlc_q;
            end else if (reg_wr && !rdy_q[i] &&
                         bank_hit(reg_addr, crh_pkg::ADDR_ID_BASE, 4'(i))) begin
               id_q[i] <= reg_wdata[28:0];
               ide_q[i] <= reg_wdata[crh_pkg::ID_IDE_BIT];
            end
         end
      end
   end

   // global masks
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         for (int k = 0; k < crh_pkg::NMASK; k++) begin
            mask_q[k] <= 29'h0000_0000;
         end
      end else begin
         for (int k = 0; k < crh_pkg::NMASK; k++) begin
            if (reg_wr && reg_addr == 8'(crh_pkg::ADDR_MASK_BASE + 8'(k))) begin
               mask_q[k] <= reg_wdata[28:0];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // buffer control flags
   // ----------------------------------------------------------------
   // set/clear pairs; a hardware set of new-data beats a cpu clear
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         for (int i = 0; i < crh_pkg::NBUF; i++) begin
            rdy_q[i] <= crh_pkg::RST_FLAG;
            dn_q[i] <= crh_pkg::RST_FLAG;
            muc_q[i] <= crh_pkg::RST_FLAG;
         end
      end else begin
         for (int i = 0; i < crh_pkg::NBUF; i++) begin
            if (reg_wr && !muc_q[i] &&
                bank_hit(reg_addr, crh_pkg::ADDR_CTRL_BASE, 4'(i))) begin
               if (reg_wdata[crh_pkg::CTRLW_SET_RDY] && !reg_wdata[crh_pkg::CTRLW_CLR_RDY]) begin
                  rdy_q[i] <= 1'b1;
               end else if (!reg_wdata[crh_pkg::CTRLW_SET_RDY] &&
                            reg_wdata[crh_pkg::CTRLW_CLR_RDY]) begin
                  rdy_q[i] <= 1'b0;
               end
            end
            if (tgt_q == 4'(i) && (st_q == crh_pkg::ST_START || copy_end)) begin
               dn_q[i] <= 1'b1;
            end else if (reg_wr && reg_wdata[crh_pkg::CTRLW_CLR_DN] &&
                         bank_hit(reg_addr, crh_pkg::ADDR_CTRL_BASE, 4'(i))) begin
               dn_q[i] <= 1'b0;
            end
            if (tgt_q == 4'(i) && st_q == crh_pkg::ST_START) begin
               muc_q[i] <= 1'b1;
            end else if (tgt_q == 4'(i) && copy_end) begin
               muc_q[i] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // receive history list
   // ----------------------------------------------------------------
   logic hist_full;
   logic hw_adv;
   logic sw_adv;
   logic hget_rd;
   logic ovf_clr;
   logic [4:0] wp_n;
   logic [4:0] rp_n;
   assign hist_full = ptr_inc(wp_q) == rp_q;
   assign hget_rd = reg_rd && reg_addr == crh_pkg::ADDR_HGET;
   assign ovf_clr = reg_wr && reg_addr == crh_pkg::ADDR_HGET &&
                    reg_wdata[crh_pkg::HGET_OVF_BIT];
   assign hw_adv = st_q == crh_pkg::ST_HIST && !hist_full;
   assign sw_adv = hget_rd && rp_q != wp_q;
   assign wp_n = hw_adv ? ptr_inc(wp_q) : wp_q;
   assign rp_n = sw_adv ? ptr_inc(rp_q) : rp_q;

   // entries are never reset, so content after mode entry is undefined
   always_ff @(posedge sys_clk) begin
      if (st_q == crh_pkg::ST_HIST) begin
         if (hist_full) begin
            hist_mem[ptr_dec(wp_q)] <= tgt_q;
         end else begin
            hist_mem[wp_q] <= tgt_q;
         end
      end
   end

   // pointers; a full list keeps the write pointer where it is
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wp_q <= crh_pkg::RST_PTR;
         rp_q <= crh_pkg::RST_PTR;
      end else begin
         wp_q <= wp_n;
         rp_q <= rp_n;
      end
   end

   // empty: read catching up sets it; a store clears it unless overflowed
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         empty_q <= crh_pkg::RST_EMPTY;
      end else if (hw_adv && !ovf_q) begin
         empty_q <= 1'b0;
      end else if (sw_adv && rp_n == wp_n) begin
         empty_q <= 1'b1;
      end
   end

   // overflow is sticky until software clears it; a set beats the clear
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ovf_q <= crh_pkg::RST_FLAG;
      end else if (hw_adv && wp_n == ptr_dec(rp_n)) begin
         ovf_q <= 1'b1;
      end else if (ovf_clr) begin
         ovf_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   // unmapped words read zero
   always_comb begin
      rdata_d = crh_pkg::RST_RDATA;
      for (int i = 0; i < crh_pkg::NBUF; i++) begin
         if (bank_hit(reg_addr, crh_pkg::ADDR_CFG_BASE, 4'(i))) begin
            rdata_d[crh_pkg::CFG_USE_BIT] = use_q[i];
            rdata_d[crh_pkg::CFG_TYPE_LSB +: 3] = type_q[i];
            rdata_d[crh_pkg::CFG_OWS_BIT] = ows_q[i];
         end
         if (bank_hit(reg_addr, crh_pkg::ADDR_CTRL_BASE, 4'(i))) begin
            rdata_d[crh_pkg::CTRL_RDY_BIT] = rdy_q[i];
            rdata_d[crh_pkg::CTRL_DN_BIT] = dn_q[i];
            rdata_d[crh_pkg::CTRL_MUC_BIT] = muc_q[i];
            rdata_d[crh_pkg::CTRL_DLC_LSB +: 4] = dlc_q[i];
         end
         if (bank_hit(reg_addr, crh_pkg::ADDR_ID_BASE, 4'(i))) begin
            rdata_d[28:0] = id_q[i];
            rdata_d[crh_pkg::ID_IDE_BIT] = ide_q[i];
         end
      end
      for (int k = 0; k < crh_pkg::NMASK; k++) begin
         if (reg_addr == 8'(crh_pkg::ADDR_MASK_BASE + 8'(k))) begin
            rdata_d[28:0] = mask_q[k];
         end
      end
      if (reg_addr == crh_pkg::ADDR_HGET) begin
         rdata_d[3:0] = hist_mem[rp_q];
         rdata_d[crh_pkg::HGET_EMPTY_BIT] = empty_q;
         rdata_d[crh_pkg::HGET_OVF_BIT] = ovf_q;
      end
      if (reg_addr == crh_pkg::ADDR_LAST) begin
         rdata_d[3:0] = hist_mem[ptr_dec(wp_q)];
      end
   end

   // data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_rdata <= crh_pkg::RST_RDATA;
      end else begin
         reg_rdata <= reg_rd ? rdata_d : crh_pkg::RST_RDATA;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   logic tgt_rdy;
   assign tgt_rdy = rdy_q[tgt_q];

   chk_elig_target: assert property (st_q == crh_pkg::ST_HIST |-> use_q[tgt_q] &&
      type_q[tgt_q] >= crh_pkg::TYPE_UNMASKED && type_q[tgt_q] <= crh_pkg::TYPE_MASK4)
      else $error("store target not eligible");
   chk_class_top: assert property (st_q == crh_pkg::ST_SEARCH && found |=>
      (st_q == crh_pkg::ST_HIST && type_q[tgt_q] == $past(best_cls)) || frame_drop)
      else $error("store not in best class");
   chk_drop_blocked: assert property (st_q == crh_pkg::ST_SEARCH && found && !free_hit &&
      !ows_hit |=> frame_drop && st_q == crh_pkg::ST_IDLE)
      else $error("blocked frame not discarded");
   chk_accept_cond: assert property (st_q == crh_pkg::ST_HIST |->
      !dn_q[tgt_q] || ows_q[tgt_q])
      else $error("stored into blocked buffer");
   chk_start_flags: assert property (st_q == crh_pkg::ST_START |=>
      muc_q[tgt_q] && dn_q[tgt_q])
      else $error("start flags missing");
   chk_end_flags: assert property (store_done |->
      !muc_q[store_buf] && dn_q[store_buf])
      else $error("end flags wrong");
   chk_rdy_lock: assert property (st_q == crh_pkg::ST_COPY && muc_q[tgt_q] && reg_wr |=>
      $stable(tgt_rdy))
      else $error("ready changed while storing");
   chk_copy_stall: assert property (st_q == crh_pkg::ST_COPY && cpu_touch |=>
      st_q == crh_pkg::ST_COPY && $stable(cnt_q))
      else $error("copy ran during cpu access");
   chk_wp_step: assert property (st_q == crh_pkg::ST_HIST && !hist_full |=>
      wp_q == ptr_inc($past(wp_q)))
      else $error("write pointer not advanced");
   chk_full_hold: assert property (st_q == crh_pkg::ST_HIST && hist_full |=>
      $stable(wp_q))
      else $error("full list advanced");
   chk_get_step: assert property (hget_rd && rp_q != wp_q |=>
      rp_q == ptr_inc($past(rp_q)))
      else $error("read pointer not advanced");
   chk_empty_match: assert property (rp_q == wp_q |-> empty_q)
      else $error("empty flag low with equal pointers");
   chk_ovf_sticky: assert property (ovf_q && !ovf_clr |=> ovf_q)
      else $error("overflow dropped without clear");
endmodule // crh_rx_store

/* verif/crh_can_engine.sv */
module crh_can_engine (
   input wire logic sys_clk, // module clock
   input wire logic srst, // synchronous reset, high
   input wire logic send, // pulse: offer one frame
   input wire logic [28:0] id, // identifier to offer
   input wire logic rx_ready, // controller takes frame
   output logic rx_valid, // frame offered
   output logic [28:0] rx_id, // offered identifier
   output logic rx_ide, // extended format
   output logic [3:0] rx_dlc // offered length code
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // frame offer: held until the edge that takes it
   // ------------------------------------------------------------
   // idle lines toggle so a stale value is never mistaken for a frame
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rx_valid <= 1'b0;
         rx_id <= 29'h0000_0000;
         rx_ide <= 1'b0;
         rx_dlc <= 4'h0;
      end else if (send) begin
         rx_valid <= 1'b1;
         rx_id <= id;
         rx_ide <= 1'b1;
         rx_dlc <= id[3:0]; // length code follows low id bits
      end else if (!rx_valid || rx_ready) begin
         rx_valid <= 1'b0;
         rx_id <= ~rx_id;
         rx_ide <= ~rx_ide;
         rx_dlc <= ~rx_dlc;
      end
   end
endmodule // crh_can_engine

/* verif/crh_rx_store_tb.sv */
module crh_rx_store_tb;
   timeunit 1ns;
   timeprecision 1ps;
   `define crh_chk(n, e, g) check_val(n, e, g)
   logic sys_clk, srst, reg_wr, reg_rd, rx_ready, store_done, frame_drop, send, rx_valid, rx_ide;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd, exp;
   logic [3:0] store_buf, rx_dlc;
   logic [28:0] rx_id, fid;
   logic empty = 1'b1, ovf = 1'b0;
   int num_errors = 0, check_count = 0, seed = 58, wp = 0, rp = 0, hist[23], lat = 0;
   localparam logic [28:0] XID = 29'h0ABC_0000;
   crh_rx_store uut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_id(rx_id),
      .rx_ide(rx_ide), .rx_dlc(rx_dlc), .rx_ready(rx_ready), .store_done(store_done),
      .store_buf(store_buf), .frame_drop(frame_drop));
   crh_can_engine eng (.sys_clk(sys_clk), .srst(srst), .send(send), .id(fid), .rx_ready(rx_ready),
      .rx_valid(rx_valid), .rx_id(rx_id), .rx_ide(rx_ide), .rx_dlc(rx_dlc));
   // ------------------------------------------------------------
   // bus, frame and history-model tasks
   // ------------------------------------------------------------
   task check_val(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(logic [7:0] a, logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rdr(logic [7:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   // exp_buf below zero means the frame must be dropped
   task send_frame(logic [28:0] id, int exp_buf);
      int n;
      @(posedge sys_clk);
      send <= 1'b1; fid <= id;
      @(posedge sys_clk);
      send <= 1'b0;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1 n++;
      end while (store_done !== 1'b1 && frame_drop !== 1'b1 && n < 40);
      lat = n;
      `crh_chk("frame dropped", {31'h0, exp_buf < 0}, {31'h0, frame_drop});
      `crh_chk("frame stored", {31'h0, exp_buf >= 0}, {31'h0, store_done});
      `crh_chk("ready after frame", 32'h1, {31'h0, rx_ready});
      if (exp_buf >= 0) begin
         `crh_chk("store buffer", 32'(exp_buf), {28'h0, store_buf});
         if (!ovf) empty = 1'b0;
         if ((wp + 1) % 23 == rp) hist[(wp + 22) % 23] = exp_buf;
         else begin
            hist[wp] = exp_buf;
            wp = (wp + 1) % 23;
            if (wp == (rp + 22) % 23) ovf = 1'b1;
         end
      end
   endtask
   // empty list: entry bits undefined, pointer holds
   task hget;
      rdr(crh_pkg::ADDR_HGET);
      exp = {22'h0, ovf, empty, 4'h0, 4'(hist[rp])};
      if (rp == wp) begin
         exp[3:0] = 4'h0;
         rd[3:0] = 4'h0;
      end
      `crh_chk("history get", exp, rd);
      if (rp != wp) rp = (rp + 1) % 23;
      if (rp == wp) empty = 1'b1;
   endtask
   task conclude;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ------------------------------------------------------------
   // clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      conclude;
   end
   initial begin
      srst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0; send = 1'b0;
      fid = 29'h0;
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      wr(8'h30, 32'h0000_FFFF); // mask 1 skips low bits
      wr(8'h33, 32'h1FFF_FFFF); // mask 4 skips every bit
      wr(8'h00, 32'h02); // unmasked, not in use
      wr(8'h01, 32'h05); // mask 1
      wr(8'h02, 32'h03); // unmasked
      wr(8'h03, 32'h1B); // mask 4, overwrite on
      for (int m = 0; m < 4; m++) begin
         wr(8'h20 + 8'(m), {3'b100, XID});
         wr(8'h10 + 8'(m), 32'h100);
      end
      send_frame(XID, 2);
      send_frame(XID, -1);
      send_frame(XID ^ 29'h1234, 1);
      rdr(8'h11);
      `crh_chk("ctrl after store", 32'h0000_0403, rd);
      // cpu pokes the target mid-copy: write refused, each access stalls one cycle
      fork
         send_frame(29'h1000_0005, 3);
         begin
            repeat (5) @(posedge sys_clk);
            wr(8'h13, 32'h1); // clear ready while copying
            rdr(8'h13);
            `crh_chk("ctrl while storing", 32'h0000_0007, rd);
         end
      join
      `crh_chk("store latency", 32'(4 + crh_pkg::STORE_CYCLES_I + 2), 32'(lat));
      rdr(8'h13);
      `crh_chk("ready locked", 32'h0000_0503, rd);
      repeat (24) send_frame({1'b1, 28'($random(seed))}, 3);
      rdr(crh_pkg::ADDR_LAST);
      `crh_chk("last in", 32'(hist[(wp + 22) % 23]), rd);
      repeat (23) hget();
      send_frame({1'b1, 28'($random(seed))}, 3);
      hget();
      wr(crh_pkg::ADDR_HGET, 32'h200);
      ovf = 1'b0;
      repeat (2) send_frame({1'b1, 28'($random(seed))}, 3);
      repeat (3) hget();
      conclude;
   end
endmodule // crh_rx_store_tb
